// ---- ispa_addr_gen.sv ----
// Operand address generator for indexed and stack-pointer-relative modes
//
// Overview of operation
// - No offset: address is whole index pair
// - Upper index stays zero unless modifier writes
// - 8-bit offset: index pair plus unsigned byte
// - 16-bit offset: index pair plus unsigned word
// - First offset byte is high, second low
// - Stack 8-bit: stack pointer plus unsigned byte
// - Stack 16-bit: stack pointer plus word
// - Stack forms need prebyte, one extra cycle
// - Prebyte and opcode form two-byte opcode field
// - Modify and test ops lack 16-bit index form
// - Stack forms: subset of ops, no jumps
module ispa_addr_gen #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Instruction byte stream
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	// Pointer state from the core
	input wire logic [7:0] index_low_in,
	input wire logic [15:0] sp_in,
	// Upper index write from the executing instruction
	input wire logic upper_load_in,
	input wire logic [7:0] upper_data_in,
	input wire logic [7:0] exec_opcode_in,
	// Address result
	output logic ea_valid_out,
	output logic [15:0] ea_out,
	output ispa_pkg::ispa_mode_e mode_out,
	output logic [2:0] length_out,
	output logic [1:0] extra_cycles_out,
	output logic [7:0] opcode_out,
	output logic prefixed_out,
	output logic rmw_out,
	output logic reject_out,
	// Sequencer and index state
	output logic busy_out,
	output logic [7:0] upper_index_out
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The index pair and all offsets are 16 bits wide
	if (ADDR_W != ispa_pkg::ISPA_ADDR_W)
	begin : g_bad_width
		$error("ispa_addr_gen: ADDR_W must be 16");
	end

	// ----------------------------------------------------------------
	// Types and state
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_OPCODE = 4'h1,
		ST_PREFIXED = 4'h2,
		ST_OFF_HI = 4'h4,
		ST_OFF_LO = 4'h8
	} ispa_state_e;

	ispa_state_e state;
	ispa_state_e next_state;
	ispa_pkg::ispa_mode_e mode;
	ispa_pkg::ispa_mode_e next_mode;
	logic [7:0] opcode;
	logic [7:0] next_opcode;
	logic [7:0] off_hi;
	logic [7:0] next_off_hi;
	logic prefixed;
	logic next_prefixed;

	logic next_ea_valid;
	logic [15:0] next_ea;
	ispa_pkg::ispa_mode_e next_mode_out;
	logic [2:0] next_length;
	logic [1:0] next_extra_cycles;
	logic [7:0] next_opcode_out;
	logic next_prefixed_out;
	logic next_rmw;
	logic next_reject;

	logic [7:0] upper;
	logic [7:0] next_upper;

	// Decode of the byte now on the stream
	ispa_pkg::ispa_mode_e dec_mode;
	logic finish;
	logic [15:0] fin_offset;

	ispa_calc_if calc_if ();

	ispa_ea_adder u_adder (
		.calc_if(calc_if.calc)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] mode_length(input ispa_pkg::ispa_mode_e m);
		logic [2:0] len;
		len = ispa_pkg::ISPA_LEN_NONE;
		case (m)
			ispa_pkg::ISPA_MODE_IX: len = ispa_pkg::ISPA_LEN_IX;
			ispa_pkg::ISPA_MODE_IX1: len = ispa_pkg::ISPA_LEN_IX1;
			ispa_pkg::ISPA_MODE_IX2: len = ispa_pkg::ISPA_LEN_IX2;
			ispa_pkg::ISPA_MODE_SP1: len = ispa_pkg::ISPA_LEN_SP1;
			ispa_pkg::ISPA_MODE_SP2: len = ispa_pkg::ISPA_LEN_SP2;
			default: len = ispa_pkg::ISPA_LEN_NONE;
		endcase
		return len;
	endfunction

	function automatic logic is_stack_mode(input ispa_pkg::ispa_mode_e m);
		return (m == ispa_pkg::ISPA_MODE_SP1) || (m == ispa_pkg::ISPA_MODE_SP2);
	endfunction

	// ----------------------------------------------------------------
	// Opcode decode and adder operands
	// ----------------------------------------------------------------
	always_comb
	begin
		// Prebyte already seen selects the stack-relative rows
		dec_mode = ispa_pkg::ispa_row_mode(byte_in, state == ST_PREFIXED);
		// Legality is judged on the live opcode before it is stored
		if (state == ST_OPCODE || state == ST_PREFIXED)
		begin
			calc_if.mode = dec_mode;
			calc_if.opcode = byte_in;
		end
		else
		begin
			calc_if.mode = mode;
			calc_if.opcode = opcode;
		end
		if (is_stack_mode(calc_if.mode))
			calc_if.base = sp_in;
		else
			calc_if.base = {upper, index_low_in};
		calc_if.offset = fin_offset;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_mode = mode;
		next_opcode = opcode;
		next_off_hi = off_hi;
		next_prefixed = prefixed;
		next_reject = 1'b0;
		finish = 1'b0;
		fin_offset = 16'h0000;
		case (state)
			ST_OPCODE:
			begin
				if (byte_valid_in)
				begin
					if (byte_in == ispa_pkg::ISPA_PREBYTE)
					begin
						next_state = ST_PREFIXED;
						next_prefixed = 1'b1;
					end
					else if (dec_mode != ispa_pkg::ISPA_MODE_NONE)
					begin
						next_mode = dec_mode;
						next_opcode = byte_in;
						next_prefixed = 1'b0;
						case (dec_mode)
							ispa_pkg::ISPA_MODE_IX:
							begin
								// Single-byte form: the pair alone is the address
								finish = 1'b1;
								fin_offset = 16'h0000;
							end
							ispa_pkg::ISPA_MODE_IX1: next_state = ST_OFF_LO;
							ispa_pkg::ISPA_MODE_IX2: next_state = ST_OFF_HI;
							default: next_state = ST_OPCODE;
						endcase
					end
				end
			end
			ST_PREFIXED:
			begin
				if (byte_valid_in)
				begin
					if (dec_mode == ispa_pkg::ISPA_MODE_NONE || !calc_if.legal)
					begin
						// Unsupported second byte: drop it and wait for a new opcode
						next_reject = 1'b1;
						next_prefixed = 1'b0;
						next_state = ST_OPCODE;
					end
					else
					begin
						next_mode = dec_mode;
						next_opcode = byte_in;
						if (dec_mode == ispa_pkg::ISPA_MODE_SP2)
							next_state = ST_OFF_HI;
						else
							next_state = ST_OFF_LO;
					end
				end
			end
			ST_OFF_HI:
			begin
				if (byte_valid_in)
				begin
					next_off_hi = byte_in;
					next_state = ST_OFF_LO;
				end
			end
			ST_OFF_LO:
			begin
				if (byte_valid_in)
				begin
					finish = 1'b1;
					if (mode == ispa_pkg::ISPA_MODE_IX2 || mode == ispa_pkg::ISPA_MODE_SP2)
						fin_offset = {off_hi, byte_in};
					else
						fin_offset = {8'h00, byte_in};
					next_state = ST_OPCODE;
				end
			end
			default:
			begin
				next_state = ST_OPCODE;
				next_prefixed = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= ST_OPCODE;
			mode <= ispa_pkg::ISPA_MODE_NONE;
			opcode <= ispa_pkg::ISPA_BYTE_RESET;
			off_hi <= ispa_pkg::ISPA_BYTE_RESET;
			prefixed <= 1'b0;
		end
		else
		begin
			state <= next_state;
			mode <= next_mode;
			opcode <= next_opcode;
			off_hi <= next_off_hi;
			prefixed <= next_prefixed;
		end
	end

	// ----------------------------------------------------------------
	// Result registers
	// ----------------------------------------------------------------
	always_comb
	begin
		next_ea_valid = finish;
		next_ea = ea_out;
		next_mode_out = mode_out;
		next_length = length_out;
		next_extra_cycles = extra_cycles_out;
		next_opcode_out = opcode_out;
		next_prefixed_out = prefixed_out;
		next_rmw = rmw_out;
		if (finish)
		begin
			next_ea = calc_if.sum;
			next_mode_out = calc_if.mode;
			next_length = mode_length(calc_if.mode);
			next_opcode_out = calc_if.opcode;
			next_prefixed_out = is_stack_mode(calc_if.mode);
			next_rmw = calc_if.rmw;
			// Prebyte fetch costs exactly one cycle over the index form
			if (is_stack_mode(calc_if.mode))
				next_extra_cycles = ispa_pkg::ISPA_PREBYTE_EXTRA_CYCLES;
			else
				next_extra_cycles = 2'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ea_valid_out <= 1'b0;
			ea_out <= ispa_pkg::ISPA_EA_RESET;
			mode_out <= ispa_pkg::ISPA_MODE_NONE;
			length_out <= ispa_pkg::ISPA_LEN_NONE;
			extra_cycles_out <= 2'h0;
			opcode_out <= ispa_pkg::ISPA_BYTE_RESET;
			prefixed_out <= 1'b0;
			rmw_out <= 1'b0;
			reject_out <= 1'b0;
		end
		else
		begin
			ea_valid_out <= next_ea_valid;
			ea_out <= next_ea;
			mode_out <= next_mode_out;
			length_out <= next_length;
			extra_cycles_out <= next_extra_cycles;
			opcode_out <= next_opcode_out;
			prefixed_out <= next_prefixed_out;
			rmw_out <= next_rmw;
			reject_out <= next_reject;
		end
	end

	// ----------------------------------------------------------------
	// Upper index byte
	// ----------------------------------------------------------------
	always_comb
	begin
		next_upper = upper;
		// Writes from any other instruction are ignored so the byte keeps its last value
		if (upper_load_in && ispa_pkg::ispa_is_upper_modifier(exec_opcode_in))
			next_upper = upper_data_in;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			upper <= ispa_pkg::ISPA_UPPER_RESET;
		else
			upper <= next_upper;
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	assign busy_out = (state != ST_OPCODE);
	assign upper_index_out = upper;

endmodule // ispa_addr_gen

// ---- ispa_addr_gen_chk.sv ----
// Port assertions for the indexed and stack-relative address generator
module ispa_addr_gen_chk #(
	parameter int ADDR_W = 16
) (
	// Watched ports
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire logic [7:0] index_low_in,
	input wire logic [15:0] sp_in,
	input wire logic upper_load_in,
	input wire logic [7:0] upper_data_in,
	input wire logic [7:0] exec_opcode_in,
	input wire logic ea_valid_out,
	input wire logic [15:0] ea_out,
	input wire ispa_pkg::ispa_mode_e mode_out,
	input wire logic [2:0] length_out,
	input wire logic [1:0] extra_cycles_out,
	input wire logic [7:0] opcode_out,
	input wire logic prefixed_out,
	input wire logic rmw_out,
	input wire logic reject_out,
	input wire logic busy_out,
	input wire logic [7:0] upper_index_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic upper_ok;

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	assign upper_ok = upper_load_in && (exec_opcode_in inside {8'hA7, 8'h71, 8'h61, 8'h45, 8'h55,
		8'h5E, 8'h7E, 8'h52, 8'h8A, 8'h95});

	ix_address_a: assert property (ea_valid_out && mode_out == ispa_pkg::ISPA_MODE_IX
		|-> ea_out == {$past(upper_index_out), $past(index_low_in)}) else $error("ix address wrong");
	ix1_address_a: assert property (ea_valid_out && mode_out == ispa_pkg::ISPA_MODE_IX1
		|-> ea_out == {$past(upper_index_out), $past(index_low_in)} + {8'h00, $past(byte_in)})
		else $error("ix1 address wrong");
	sp1_address_a: assert property (ea_valid_out && mode_out == ispa_pkg::ISPA_MODE_SP1
		|-> ea_out == $past(sp_in) + {8'h00, $past(byte_in)}) else $error("sp1 address wrong");
	mode_length_a: assert property (ea_valid_out |-> length_out ==
		(mode_out == ispa_pkg::ISPA_MODE_IX ? 3'h1 : mode_out == ispa_pkg::ISPA_MODE_IX1 ? 3'h2 :
		mode_out == ispa_pkg::ISPA_MODE_SP2 ? 3'h4 : 3'h3)) else $error("length wrong");
	stack_extra_a: assert property (ea_valid_out |-> extra_cycles_out == {1'b0, prefixed_out} &&
		prefixed_out == (mode_out inside {ispa_pkg::ISPA_MODE_SP1, ispa_pkg::ISPA_MODE_SP2}))
		else $error("extra cycle wrong");
	upper_hold_a: assert property (!upper_ok |=> $stable(upper_index_out))
		else $error("upper byte changed");
	upper_load_a: assert property (upper_ok |=> upper_index_out == $past(upper_data_in))
		else $error("upper byte not loaded");
	rmw_short_a: assert property (ea_valid_out && rmw_out
		|-> !(mode_out inside {ispa_pkg::ISPA_MODE_IX2, ispa_pkg::ISPA_MODE_SP2}))
		else $error("rmw in 16-bit mode");
endmodule // ispa_addr_gen_chk

// ---- ispa_calc_if.sv ----
// Carrier between the sequencer and the address adder
interface ispa_calc_if;
	logic [15:0] base;
	logic [15:0] offset;
	logic [15:0] sum;
	logic [7:0] opcode;
	ispa_pkg::ispa_mode_e mode;
	logic legal;
	logic rmw;

	modport core (output base, output offset, output opcode, output mode, input sum, input legal, input rmw);
	modport calc (input base, input offset, input opcode, input mode, output sum, output legal, output rmw);
endinterface

// ---- ispa_ea_adder.sv ----
// Effective-address adder and per-mode legality check
module ispa_ea_adder (
	// Operands and result
	ispa_calc_if.calc calc_if
);

	// ----------------------------------------------------------------
	// Sum and legality
	// ----------------------------------------------------------------
	always_comb
	begin
		// Carry out of bit 15 is dropped on purpose, no flag is made
		calc_if.sum = calc_if.base + calc_if.offset;
		calc_if.rmw = (calc_if.opcode[7:4] == ispa_pkg::ISPA_ROW_IX_RMW) ||
			(calc_if.opcode[7:4] == ispa_pkg::ISPA_ROW_IX1_RMW);
		case (calc_if.mode)
			ispa_pkg::ISPA_MODE_IX, ispa_pkg::ISPA_MODE_IX1: calc_if.legal = 1'b1;
			ispa_pkg::ISPA_MODE_IX2: calc_if.legal = !calc_if.rmw;
			ispa_pkg::ISPA_MODE_SP1:
			begin
				if (calc_if.rmw)
					calc_if.legal = !ispa_pkg::ispa_is_rmw_gap(calc_if.opcode[3:0]);
				else
					calc_if.legal = (calc_if.opcode[3:0] != ispa_pkg::ISPA_LO_JUMP) &&
						(calc_if.opcode[3:0] != ispa_pkg::ISPA_LO_CALL);
			end
			ispa_pkg::ISPA_MODE_SP2:
				calc_if.legal = !calc_if.rmw && (calc_if.opcode[3:0] != ispa_pkg::ISPA_LO_JUMP) &&
					(calc_if.opcode[3:0] != ispa_pkg::ISPA_LO_CALL);
			default: calc_if.legal = 1'b0;
		endcase
	end

endmodule // ispa_ea_adder

// ---- ispa_mem_model.sv ----
// Program memory model streaming instruction bytes to the generator
module ispa_mem_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Stream control
	input wire logic stall_in,
	// Byte stream
	output logic byte_valid_out = 1'b0,
	output logic [7:0] byte_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] fifo [$];

	task automatic push(input logic [7:0] b);
		fifo.push_back(b);
	endtask

	// Idle cycles show the inverted byte so a stale value never passes
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			byte_valid_out <= 1'b0;
			byte_out <= 8'h00;
		end
		else if (fifo.size() != 0 && !stall_in)
		begin
			byte_valid_out <= 1'b1;
			byte_out <= fifo.pop_front();
		end
		else
		begin
			byte_valid_out <= 1'b0;
			byte_out <= ~byte_out;
		end
	end
endmodule // ispa_mem_model

// ---- ispa_pkg.sv ----
// Constants, types and decode helpers for the indexed and stack-relative address generator
package ispa_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int ISPA_ADDR_W = 16;
	localparam logic [7:0] ISPA_UPPER_RESET = 8'h00;
	localparam logic [15:0] ISPA_EA_RESET = 16'h0000;
	localparam logic [7:0] ISPA_BYTE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Opcode map fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ISPA_PREBYTE = 8'h9E;
	localparam logic [3:0] ISPA_ROW_IX_ALU = 4'hF;
	localparam logic [3:0] ISPA_ROW_IX1_ALU = 4'hE;
	localparam logic [3:0] ISPA_ROW_IX2_ALU = 4'hD;
	localparam logic [3:0] ISPA_ROW_IX_RMW = 4'h7;
	localparam logic [3:0] ISPA_ROW_IX1_RMW = 4'h6;
	localparam logic [3:0] ISPA_LO_JUMP = 4'hC;
	localparam logic [3:0] ISPA_LO_CALL = 4'hD;
	localparam logic [3:0] ISPA_LO_CMP_BRANCH = 4'h1;
	localparam logic [3:0] ISPA_LO_GAP_A = 4'h2;
	localparam logic [3:0] ISPA_LO_GAP_B = 4'h5;
	localparam logic [3:0] ISPA_LO_GAP_C = 4'hE;

	// Instructions allowed to change the upper index byte
	localparam logic [7:0] ISPA_OP_ADD_IMM_TO_POINTER = 8'hA7;
	localparam logic [7:0] ISPA_OP_CBR_EQ_POSTINC = 8'h71;
	localparam logic [7:0] ISPA_OP_CBR_EQ_OFF_POSTINC = 8'h61;
	localparam logic [7:0] ISPA_OP_LOAD_PAIR_IMM = 8'h45;
	localparam logic [7:0] ISPA_OP_LOAD_PAIR_DIR = 8'h55;
	localparam logic [7:0] ISPA_OP_MOVE_DIR_POSTINC = 8'h5E;
	localparam logic [7:0] ISPA_OP_MOVE_POSTINC_DIR = 8'h7E;
	localparam logic [7:0] ISPA_OP_DIVIDE = 8'h52;
	localparam logic [7:0] ISPA_OP_PULL_UPPER = 8'h8A;
	localparam logic [7:0] ISPA_OP_STACK_TO_POINTER = 8'h95;

	// ----------------------------------------------------------------
	// Instruction lengths and cycle figures
	// ----------------------------------------------------------------
	localparam logic [2:0] ISPA_LEN_NONE = 3'h0;
	localparam logic [2:0] ISPA_LEN_IX = 3'h1;
	localparam logic [2:0] ISPA_LEN_IX1 = 3'h2;
	localparam logic [2:0] ISPA_LEN_IX2 = 3'h3;
	localparam logic [2:0] ISPA_LEN_SP1 = 3'h3;
	localparam logic [2:0] ISPA_LEN_SP2 = 3'h4;
	localparam logic [1:0] ISPA_PREBYTE_EXTRA_CYCLES = 2'h1;

	typedef enum logic [4:0] {
		ISPA_MODE_NONE = 5'h00,
		ISPA_MODE_IX = 5'h01,
		ISPA_MODE_IX1 = 5'h02,
		ISPA_MODE_IX2 = 5'h04,
		ISPA_MODE_SP1 = 5'h08,
		ISPA_MODE_SP2 = 5'h10
	} ispa_mode_e;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic ispa_is_rmw_gap(input logic [3:0] lo);
		return (lo == ISPA_LO_GAP_A) || (lo == ISPA_LO_GAP_B) || (lo == ISPA_LO_GAP_C);
	endfunction

	// Addressing mode selected by an opcode, with or without the prebyte
	function automatic ispa_mode_e ispa_row_mode(input logic [7:0] opc, input logic pre);
		ispa_mode_e m;
		m = ISPA_MODE_NONE;
		if (!pre)
		begin
			case (opc[7:4])
				ISPA_ROW_IX_ALU: m = ISPA_MODE_IX;
				ISPA_ROW_IX1_ALU: m = ISPA_MODE_IX1;
				ISPA_ROW_IX2_ALU: m = ISPA_MODE_IX2;
				ISPA_ROW_IX_RMW, ISPA_ROW_IX1_RMW:
				begin
					// Post-increment compare and the gaps belong to other modes
					if (!ispa_is_rmw_gap(opc[3:0]) && opc[3:0] != ISPA_LO_CMP_BRANCH)
						m = (opc[7:4] == ISPA_ROW_IX_RMW) ? ISPA_MODE_IX : ISPA_MODE_IX1;
				end
				default: m = ISPA_MODE_NONE;
			endcase
		end
		else
		begin
			case (opc[7:4])
				ISPA_ROW_IX1_ALU, ISPA_ROW_IX1_RMW: m = ISPA_MODE_SP1;
				ISPA_ROW_IX2_ALU: m = ISPA_MODE_SP2;
				default: m = ISPA_MODE_NONE;
			endcase
		end
		return m;
	endfunction

	function automatic logic ispa_is_upper_modifier(input logic [7:0] opc);
		return (opc == ISPA_OP_ADD_IMM_TO_POINTER) || (opc == ISPA_OP_CBR_EQ_POSTINC) ||
			(opc == ISPA_OP_CBR_EQ_OFF_POSTINC) || (opc == ISPA_OP_LOAD_PAIR_IMM) ||
			(opc == ISPA_OP_LOAD_PAIR_DIR) || (opc == ISPA_OP_MOVE_DIR_POSTINC) ||
			(opc == ISPA_OP_MOVE_POSTINC_DIR) || (opc == ISPA_OP_DIVIDE) ||
			(opc == ISPA_OP_PULL_UPPER) || (opc == ISPA_OP_STACK_TO_POINTER);
	endfunction

endpackage

// ---- tb_top.sv ----
// Self-checking bench for the indexed and stack-relative address generator
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic stall_en = 1'b0;
	logic stall = 1'b0;
	logic byte_valid;
	logic [7:0] byte_val;
	logic [7:0] index_low = 8'h00;
	logic [15:0] sp = 16'h0000;
	logic upper_load = 1'b0;
	logic [7:0] upper_data = 8'h00;
	logic [7:0] exec_op = 8'h00;
	logic ea_valid;
	logic prefixed;
	logic rmw;
	logic reject;
	logic [15:0] ea;
	ispa_pkg::ispa_mode_e mode;
	logic [2:0] len;
	logic [1:0] extra;
	logic [7:0] opcode;
	logic [7:0] upper;
	logic got_ea;
	logic got_rej;
	logic busy;
	logic got_busy;
	int bad_count = 0;
	int n_tests = 0;

	always #25 clk_in = ~clk_in;
	// Gaps between bytes prove the stream may stall mid-instruction
	always @(posedge clk_in) stall <= stall_en & ~stall;

	ispa_mem_model mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(stall),
		.byte_valid_out(byte_valid), .byte_out(byte_val));
	ispa_addr_gen DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .byte_valid_in(byte_valid),
		.byte_in(byte_val), .index_low_in(index_low), .sp_in(sp), .upper_load_in(upper_load),
		.upper_data_in(upper_data), .exec_opcode_in(exec_op), .ea_valid_out(ea_valid), .ea_out(ea),
		.mode_out(mode), .length_out(len), .extra_cycles_out(extra), .opcode_out(opcode),
		.prefixed_out(prefixed), .rmw_out(rmw), .reject_out(reject), .busy_out(busy),
		.upper_index_out(upper));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_res(input logic [31:0] w, input int n);
		@(negedge clk_in);
		for (int i = n - 1; i >= 0; i--)
			mem.push(w[8*i +: 8]);
		got_ea = 1'b0;
		got_rej = 1'b0;
		got_busy = 1'b0;
		for (int i = 0; i < 40 && !got_ea && !got_rej; i++)
		begin
			@(negedge clk_in);
			got_busy = got_busy | (busy === 1'b1);
			got_ea = (ea_valid === 1'b1);
			got_rej = (reject === 1'b1);
		end
	endtask

	task automatic run_ea(input logic [31:0] w, input int n, input logic [15:0] e,
		input logic [4:0] m, input logic [2:0] l);
		wait_res(w, n);
		chk("ea_valid", 16'h0001, {15'h0000, got_ea});
		chk("ea", e, ea);
		chk("mode", {11'h000, m}, {11'h000, mode});
		chk("length", {13'h0000, l}, {13'h0000, len});
		chk("extra", {15'h0000, m >= 5'h08}, {14'h0000, extra});
		// Only multi-byte forms leave the opcode wait state
		chk("busy_seen", {15'h0000, l != 3'h1}, {15'h0000, got_busy});
		chk("busy", 16'h0000, {15'h0000, busy});
	endtask

	task automatic set_upper(input logic [7:0] op, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk_in);
		upper_load <= 1'b1;
		exec_op <= op;
		upper_data <= d;
		@(posedge clk_in);
		upper_load <= 1'b0;
		@(negedge clk_in);
		chk("upper", {8'h00, e}, {8'h00, upper});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_upper();
		logic [7:0] mods [10] = '{8'hA7, 8'h71, 8'h61, 8'h45, 8'h55, 8'h5E, 8'h7E, 8'h52, 8'h8A, 8'h95};
		chk("upper", 16'h0000, {8'h00, upper});
		for (int i = 0; i < 10; i++)
			set_upper(mods[i], 8'h10 + 8'(i), 8'h10 + 8'(i));
		set_upper(8'hAB, 8'h55, 8'h19);
	endtask

	task automatic t_indexed();
		set_upper(8'h45, 8'h12, 8'h12);
		@(posedge clk_in);
		index_low <= 8'h34;
		run_ea(32'hFC, 1, 16'h1234, ispa_pkg::ISPA_MODE_IX, 3'h1);
		set_upper(8'h45, 8'hFF, 8'hFF);
		@(posedge clk_in);
		index_low <= 8'hF0;
		// Sum passes FFFF and must wrap to the bottom page
		run_ea(32'hECFF, 2, 16'h00EF, ispa_pkg::ISPA_MODE_IX1, 3'h2);
		set_upper(8'h45, 8'h00, 8'h00);
		@(posedge clk_in);
		index_low <= 8'h01;
		stall_en <= 1'b1;
		run_ea(32'hDC10FF, 3, 16'h1100, ispa_pkg::ISPA_MODE_IX2, 3'h3);
		stall_en <= 1'b0;
	endtask

	task automatic t_stack();
		@(posedge clk_in);
		sp <= 16'h00FF;
		run_ea(32'h9EE710, 3, 16'h010F, ispa_pkg::ISPA_MODE_SP1, 3'h3);
		chk("opcode", 16'h00E7, {8'h00, opcode});
		chk("prefixed", 16'h0001, {15'h0000, prefixed});
		run_ea(32'h9ED60250, 4, 16'h034F, ispa_pkg::ISPA_MODE_SP2, 3'h4);
		@(posedge clk_in);
		sp <= 16'hFFFF;
		run_ea(32'h9ED60002, 4, 16'h0001, ispa_pkg::ISPA_MODE_SP2, 3'h4);
		run_ea(32'h9E6110, 3, 16'h000F, ispa_pkg::ISPA_MODE_SP1, 3'h3);
	endtask

	task automatic t_refuse();
		logic [15:0] bad [4] = '{16'h9EDC, 16'h9EED, 16'h9E7A, 16'h9E65};
		for (int i = 0; i < 4; i++)
		begin
			wait_res({16'h0000, bad[i]}, 2);
			chk("reject", 16'h0001, {15'h0000, got_rej});
			chk("busy", 16'h0000, {15'h0000, busy});
		end
	endtask

	task automatic t_rmw();
		run_ea(32'h7A, 1, 16'h0001, ispa_pkg::ISPA_MODE_IX, 3'h1);
		chk("rmw", 16'h0001, {15'h0000, rmw});
		run_ea(32'h6A05, 2, 16'h0006, ispa_pkg::ISPA_MODE_IX1, 3'h2);
		@(posedge clk_in);
		sp <= 16'h0100;
		run_ea(32'h9E6B10, 3, 16'h0110, ispa_pkg::ISPA_MODE_SP1, 3'h3);
		chk("rmw", 16'h0001, {15'h0000, rmw});
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(negedge clk_in);
		t_upper();
		t_indexed();
		t_rmw();
		t_stack();
		t_refuse();
		report_and_stop();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (4000) @(posedge clk_in);
		bad_count++;
		report_and_stop();
	end
endmodule // tb_top

bind ispa_addr_gen ispa_addr_gen_chk #(.ADDR_W(ADDR_W)) chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.byte_valid_in(byte_valid_in), .byte_in(byte_in), .index_low_in(index_low_in), .sp_in(sp_in),
	.upper_load_in(upper_load_in), .upper_data_in(upper_data_in), .exec_opcode_in(exec_opcode_in),
	.ea_valid_out(ea_valid_out), .ea_out(ea_out), .mode_out(mode_out), .length_out(length_out),
	.extra_cycles_out(extra_cycles_out), .opcode_out(opcode_out), .prefixed_out(prefixed_out),
	.rmw_out(rmw_out), .reject_out(reject_out), .busy_out(busy_out), .upper_index_out(upper_index_out));
